// *** cache_id_ras_defs.svh ***
// Offsets, field positions, fixed values and masks of the cache id / RAS register bank.
// Assumes a 32-bit AXI4-Lite register window with byte addresses.
`ifndef CACHE_ID_RAS_DEFS_SVH
`define CACHE_ID_RAS_DEFS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CACHE_TYPE   6'h00
`define OFS_ZERO_BLOCK   6'h04
`define OFS_DES_LO       6'h08
`define OFS_DES_HI       6'h0c
`define OFS_REC_COUNT    6'h10
`define OFS_PICK_LO      6'h14
`define OFS_PICK_HI      6'h18
`define OFS_ADDR_VIEW_LO 6'h20
`define OFS_ADDR_VIEW_HI 6'h24
`define OFS_CTRL_VIEW_LO 6'h28
`define OFS_CTRL_VIEW_HI 6'h2c
`define OFS_FEAT_VIEW_LO 6'h30
`define OFS_FEAT_VIEW_HI 6'h34

// ************************************************************
// Field values and positions
// ************************************************************
`define LOG2_16_WORDS    4'h4
`define L1I_PIPT         2'h3
`define FSC_ASYNC_SERR   6'h11
`define DES_FLAG_BIT     31
`define DES_WMASK        32'h80001c3f
`define REC_COUNT_ONE    16'h0001
`define REC_COUNT_TWO    16'h0002
`define PICK_RESET       1'b0

// ************************************************************
// Bus answers
// ************************************************************
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// *** cache_id_ras_pkg.sv ***
// Types shared by the cache id / RAS register bank.
// Assumes nothing of its surroundings.
package cache_id_ras_pkg;

  // Which register of an error record a forwarded write names
  typedef enum logic [1:0] {
    REC_ADDR = 2'b00,
    REC_CTRL = 2'b01,
    REC_FEAT = 2'b10
  } rec_reg_t;

endpackage : cache_id_ras_pkg

// *** cache_id_ras_sysregs.sv ***
// Cache identification and RAS error-record system registers behind an AXI4-Lite slave.
// Assumes one clock, synchronous inputs, and error records kept outside this block.
`timescale 1ns/100ps
`default_nettype none
`include "cache_id_ras_defs.svh"

module cache_id_ras_sysregs
  import cache_id_ras_pkg::*;
#(
  parameter bit SHARED_UNIT_PRESENT = 1'b1,
  parameter bit ICACHE_HW_COHERENT = 1'b1,
  parameter int ADDR_W = 6
)(
  input wire logic aclk,                    // Core clock, 40 MHz
  input wire logic aresetn,                 // Warm reset, sync, active low
  input wire logic cold_resetn,             // Cold reset, sync, active low
  input wire logic ce,                      // Clock enable, freezes all state
  input wire logic [ADDR_W-1:0] awaddr,     // Write address
  input wire logic [2:0] awprot,            // Unused protection
  input wire logic awvalid,                 // Write address valid
  output logic awready,                     // Write address ready
  input wire logic [31:0] wdata,            // Write data
  input wire logic [3:0] wstrb,             // Write byte strobes
  input wire logic wvalid,                  // Write data valid
  output logic wready,                      // Write data ready
  output logic [1:0] bresp,                 // Write response
  output logic bvalid,                      // Write response valid
  input wire logic bready,                  // Write response ready
  input wire logic [ADDR_W-1:0] araddr,     // Read address
  input wire logic [2:0] arprot,            // Unused protection
  input wire logic arvalid,                 // Read address valid
  output logic arready,                     // Read address ready
  output logic [31:0] rdata,                // Read data
  output logic [1:0] rresp,                 // Read response
  output logic rvalid,                      // Read data valid
  input wire logic rready,                  // Read data ready
  input wire logic broadcast_maint_pou_pin, // Broadcast maintenance level
  input wire logic esb_defer,               // Barrier deferred an error, pulse
  input wire logic [2:0] esb_error_kind,    // Core state of that error
  input wire logic [63:0] core_addr_in,     // Core record address register
  input wire logic [63:0] core_ctrl_in,     // Core record control register
  input wire logic [63:0] core_feat_in,     // Core record feature register
  input wire logic [63:0] shared_addr_in,   // Shared record address register
  input wire logic [63:0] shared_ctrl_in,   // Shared record control register
  input wire logic [63:0] shared_feat_in,   // Shared record feature register
  output logic core_rec_wr,                 // Write pulse to core record
  output logic shared_rec_wr,               // Write pulse to shared record
  output var rec_reg_t rec_wreg,            // Which record register is written
  output logic rec_whi,                     // Upper word when high
  output logic [31:0] rec_wdata,            // Forwarded write data
  output logic [3:0] rec_wstrb              // Forwarded byte strobes
);

  // ************************************************************
  // Parameter checks
  // ************************************************************
  // The map reaches offset 0x34, so six address bits are the least
  if (ADDR_W < 6) begin : g_bad_addr_w
    $error("ADDR_W must be at least 6");
  end

  // ************************************************************
  // Bus holding registers
  // ************************************************************
  logic aw_held_r;
  logic [5:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  // Handshakes are gated by ce so a frozen block takes nothing
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire ar_hs = arvalid && arready;
  wire wr_go = ce && aw_held_r && w_held_r && !bvalid_r;
  assign awready = ce && !aw_held_r && !bvalid_r;
  assign wready = ce && !w_held_r && !bvalid_r;
  assign arready = ce && !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [31:0] des_r;
  logic [31:0] des_nxt;
  logic pick_r;
  logic pick_nxt;

  // Identification words, fixed except cache type bit 28, the inverted pin
  wire [31:0] cache_type_val = {1'b1, 1'b0,
                                ICACHE_HW_COHERENT,
                                ~broadcast_maint_pou_pin,
                                `LOG2_16_WORDS,
                                `LOG2_16_WORDS,
                                `LOG2_16_WORDS,
                                `L1I_PIPT,
                                10'h000,
                                `LOG2_16_WORDS};
  wire [31:0] zero_block_val = {28'h0000000, `LOG2_16_WORDS};
  wire [31:0] rec_count_val = {16'h0000, SHARED_UNIT_PRESENT ? `REC_COUNT_TWO : `REC_COUNT_ONE};

  // Without a shared unit, record 1 is absent
  wire pick_absent = pick_r && !SHARED_UNIT_PRESENT;
  wire [63:0] addr_view = pick_absent ? 64'h0 : (pick_r ? shared_addr_in : core_addr_in);
  wire [63:0] ctrl_view = pick_absent ? 64'h0 : (pick_r ? shared_ctrl_in : core_ctrl_in);
  wire [63:0] feat_view = pick_absent ? 64'h0 : (pick_r ? shared_feat_in : core_feat_in);

  // ************************************************************
  // Read decode
  // ************************************************************
  logic [31:0] rd_val;
  logic rd_hit;
  wire [5:0] ra = araddr[5:0];

  // Word-aligned decode of the low six address bits; any other offset answers SLVERR
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    if (ra == `OFS_CACHE_TYPE)
      rd_val = cache_type_val;
    else if (ra == `OFS_ZERO_BLOCK)
      rd_val = zero_block_val;
    else if (ra == `OFS_DES_LO)
      rd_val = des_r;
    else if (ra == `OFS_DES_HI)
      rd_val = 32'h00000000;
    else if (ra == `OFS_REC_COUNT)
      rd_val = rec_count_val;
    else if (ra == `OFS_PICK_LO)
      rd_val = {31'h00000000, pick_r};
    else if (ra == `OFS_PICK_HI)
      rd_val = 32'h00000000;
    else if (ra == `OFS_ADDR_VIEW_LO)
      rd_val = addr_view[31:0];
    else if (ra == `OFS_ADDR_VIEW_HI)
      rd_val = addr_view[63:32];
    else if (ra == `OFS_CTRL_VIEW_LO)
      rd_val = ctrl_view[31:0];
    else if (ra == `OFS_CTRL_VIEW_HI)
      rd_val = ctrl_view[63:32];
    else if (ra == `OFS_FEAT_VIEW_LO)
      rd_val = feat_view[31:0];
    else if (ra == `OFS_FEAT_VIEW_HI)
      rd_val = feat_view[63:32];
    else
      rd_hit = 1'b0;
  end

  // ************************************************************
  // Write decode
  // ************************************************************
  wire [31:0] strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire wa_ro = (aw_addr_r == `OFS_CACHE_TYPE) || (aw_addr_r == `OFS_ZERO_BLOCK) ||
               (aw_addr_r == `OFS_REC_COUNT);
  wire wa_rw = (aw_addr_r == `OFS_DES_LO) || (aw_addr_r == `OFS_DES_HI) ||
               (aw_addr_r == `OFS_PICK_LO) || (aw_addr_r == `OFS_PICK_HI);
  wire wa_view_lo = (aw_addr_r == `OFS_ADDR_VIEW_LO) || (aw_addr_r == `OFS_CTRL_VIEW_LO) ||
                    (aw_addr_r == `OFS_FEAT_VIEW_LO);
  wire wa_view_hi = (aw_addr_r == `OFS_ADDR_VIEW_HI) || (aw_addr_r == `OFS_CTRL_VIEW_HI) ||
                    (aw_addr_r == `OFS_FEAT_VIEW_HI);
  wire wa_view = wa_view_lo || wa_view_hi;
  wire wa_hit = wa_ro || wa_rw || wa_view;
  wire [3:0] wa_word = aw_addr_r[5:2];
  wire rec_is_addr = (wa_word == 4'h8) || (wa_word == 4'h9);
  wire rec_is_ctrl = (wa_word == 4'ha) || (wa_word == 4'hb);
  wire rec_pick_wr = wr_go && wa_view && !pick_absent;
  wire des_wr = wr_go && (aw_addr_r == `OFS_DES_LO);
  wire pick_wr = wr_go && (aw_addr_r == `OFS_PICK_LO) && w_strb_r[0];

  // Deferred error status: software write, then the hardware set wins
  wire [31:0] des_m = strb_mask & `DES_WMASK;
  always_comb
  begin
    des_nxt = des_r;
    if (des_wr)
      des_nxt = (des_r & ~des_m) | (w_data_r & des_m);
    if (esb_defer)
    begin
      des_nxt[`DES_FLAG_BIT] = 1'b1;
      des_nxt[12:10] = esb_error_kind;
      des_nxt[5:0] = `FSC_ASYNC_SERR;
    end
  end

  // Only bit 0 of the select register is stored
  assign pick_nxt = pick_wr ? w_data_r[0] : pick_r;

  // ************************************************************
  // Write channel
  // ************************************************************
  // Address and data are held separately so either may arrive first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 6'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_hs)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr[5:0];
      end
      if (w_hs)
      begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_go)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wa_hit && aw_addr_r[1:0] == 2'b00) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h00000000;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        rvalid_r <= 1'b1;
        rresp_r <= (rd_hit && ra[1:0] == 2'b00) ? `RESP_OKAY : `RESP_SLVERR;
        rdata_r <= rd_val;
      end
      else if (rvalid_r && rready)
        rvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // Stored registers
  // ************************************************************
  // Deferred error status clears on warm reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      des_r <= 32'h00000000;
    else if (ce)
      des_r <= des_nxt;
  end

  // Select keeps its value through warm reset; cold reset alone clears it
  always_ff @(posedge aclk)
  begin
    if (!cold_resetn)
      pick_r <= `PICK_RESET;
    else if (ce && aresetn)
      pick_r <= pick_nxt;
  end

  // ************************************************************
  // Forwarded record writes
  // ************************************************************
  // Registered one-cycle pulse, steered by the select bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_rec_wr <= 1'b0;
      shared_rec_wr <= 1'b0;
      rec_wreg <= REC_ADDR;
      rec_whi <= 1'b0;
      rec_wdata <= 32'h00000000;
      rec_wstrb <= 4'h0;
    end
    else if (ce)
    begin
      core_rec_wr <= rec_pick_wr && !pick_r;
      shared_rec_wr <= rec_pick_wr && pick_r;
      if (rec_pick_wr)
      begin
        rec_wreg <= rec_is_addr ? REC_ADDR : (rec_is_ctrl ? REC_CTRL : REC_FEAT);
        rec_whi <= wa_view_hi;
        rec_wdata <= w_data_r;
        rec_wstrb <= w_strb_r;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire rd_ctr = ce && ar_hs && ra == `OFS_CACHE_TYPE;
  wire rd_feat0 = ce && ar_hs && ra == `OFS_FEAT_VIEW_LO && !pick_r;

  sequence s_view_wr_core;
    wr_go && wa_view && aw_addr_r == `OFS_ADDR_VIEW_LO && !pick_r;
  endsequence

  property p_ctr_fixed;
    rd_ctr |=> rvalid && rdata[31] && !rdata[30] && rdata[13:4] == 10'h000;
  endproperty
  a_ctr_fixed: assert property (p_ctr_fixed) else $error("cache type fixed bits wrong");
  property p_ctr_idc;
    rd_ctr |=> rdata[28] == !$past(broadcast_maint_pou_pin);
  endproperty
  a_ctr_idc: assert property (p_ctr_idc) else $error("clean bit not inverse of pin");
  property p_ctr_geom;
    rd_ctr |=> rdata[27:16] == 12'h444 && rdata[15:14] == 2'h3 && rdata[3:0] == 4'h4;
  endproperty
  a_ctr_geom: assert property (p_ctr_geom) else $error("cache geometry fields wrong");
  property p_zero_blk;
    ce && ar_hs && ra == `OFS_ZERO_BLOCK |=> rdata == 32'h00000004;
  endproperty
  a_zero_blk: assert property (p_zero_blk) else $error("zero block register wrong");
  property p_des_set;
    ce && esb_defer |=> des_r[31] && des_r[5:0] == 6'h11 && !des_r[24];
  endproperty
  a_des_set: assert property (p_des_set) else $error("deferred error not recorded");
  property p_des_kind;
    ce && esb_defer |=> des_r[12:10] == $past(esb_error_kind);
  endproperty
  a_des_kind: assert property (p_des_kind) else $error("error kind not captured");
  property p_count;
    ce && ar_hs && ra == `OFS_REC_COUNT |=> rdata == (SHARED_UNIT_PRESENT ? 32'h2 : 32'h1);
  endproperty
  a_count: assert property (p_count) else $error("record count wrong");
  property p_pick_warm;
    disable iff (!cold_resetn) !aresetn |=> $stable(pick_r);
  endproperty
  a_pick_warm: assert property (p_pick_warm) else $error("select lost on warm reset");

  property p_addr_route;
    s_view_wr_core |=> core_rec_wr && !shared_rec_wr && rec_wreg == REC_ADDR && !rec_whi;
  endproperty
  a_addr_route: assert property (p_addr_route) else $error("address view misrouted");

  property p_feat0;
    rd_feat0 |=> rdata == $past(core_feat_in[31:0]);
  endproperty
  a_feat0: assert property (p_feat0) else $error("feature view not core record");

  property p_absent;
    !SHARED_UNIT_PRESENT && pick_r |=> !shared_rec_wr && !core_rec_wr;
  endproperty
  a_absent: assert property (p_absent) else $error("write to absent record");

endmodule : cache_id_ras_sysregs
`default_nettype wire

// *** cache_id_ras_sysregs_tb.sv ***
// Self-checking bench for the cache id / RAS register bank over AXI4-Lite.
// Assumes the bank's header and package are compiled first; records are modelled behind it.
`timescale 1ns/100ps
`default_nettype none
`include "cache_id_ras_defs.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module cache_id_ras_sysregs_tb;
  import cache_id_ras_pkg::*;
  logic aclk, aresetn, cold_resetn, pin, defer;
  logic [2:0] kind;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rec_wdata;
  logic [3:0] wstrb, rec_wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic ce, bready, rready;
  logic [1:0] bresp, rresp;
  logic core_rec_wr, shared_rec_wr, rec_whi;
  rec_reg_t rec_wreg;
  logic [63:0] rq [2][3];
  int error_cnt = 0;
  int n_tests = 0;

  // ************************************************************
  // Clock, design and record model
  // ************************************************************
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Clock enable and response readies come from the bench, so freezing is exercised; bready rises a cycle ahead of bvalid, rready with rvalid
  cache_id_ras_sysregs #(.SHARED_UNIT_PRESENT(1'b1), .ICACHE_HW_COHERENT(1'b1), .ADDR_W(6)) dut (
    .aclk(aclk), .aresetn(aresetn), .cold_resetn(cold_resetn), .ce(ce),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .broadcast_maint_pou_pin(pin),
    .esb_defer(defer), .esb_error_kind(kind), .core_addr_in(rq[0][0]), .core_ctrl_in(rq[0][1]),
    .core_feat_in(rq[0][2]), .shared_addr_in(rq[1][0]), .shared_ctrl_in(rq[1][1]),
    .shared_feat_in(rq[1][2]), .core_rec_wr(core_rec_wr), .shared_rec_wr(shared_rec_wr),
    .rec_wreg(rec_wreg), .rec_whi(rec_whi), .rec_wdata(rec_wdata), .rec_wstrb(rec_wstrb));

  err_record_model recs (
    .aclk(aclk), .cold_resetn(cold_resetn), .core_rec_wr(core_rec_wr), .shared_rec_wr(shared_rec_wr),
    .rec_wreg(rec_wreg), .rec_whi(rec_whi), .rec_wdata(rec_wdata), .rec_wstrb(rec_wstrb), .rec_q(rq));

  // ************************************************************
  // Expected values and bus tasks
  // ************************************************************
  // Fixed cache geometry word for a given pin level
  function automatic logic [31:0] ctype(input logic p);
    return {1'b1, 1'b0, 1'b1, ~p, 4'h4, 4'h4, 4'h4, 2'h3, 10'h0, 4'h4};
  endfunction : ctype

  // Reset contents of one word of the modelled records
  function automatic logic [31:0] iv(input int r, input int k, input bit hi);
    return {hi ? 16'hface : 16'hcafe, 8'(r), 8'(k)};
  endfunction : iv

  // Address and data offered together, each released when taken
  task automatic wrc(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    bit aw_d;
    bit w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_d && w_d))
    begin
      @(posedge aclk);
      if (!aw_d && awready === 1'b1)
      begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready === 1'b1)
      begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wrc

  // Data is only meaningful on an OKAY answer
  task automatic rdc(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(rresp, er)
    if (er == `RESP_OKAY) `CHK(rdata, e)
  endtask : rdc

  task automatic defer_pulse(input logic [2:0] k);
    defer <= 1'b1;
    kind <= k;
    @(posedge aclk);
    defer <= 1'b0;
    @(posedge aclk);
  endtask : defer_pulse

  task automatic rst(input bit cold);
    aresetn <= 1'b0;
    cold_resetn <= ~cold;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cold_resetn <= 1'b1;
    @(posedge aclk);
  endtask : rst

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // ************************************************************
  // Tests
  // ************************************************************
  // Generous bound: the whole sequence needs under two hundred cycles
  initial
  begin
    repeat (4000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    aresetn = 1'b0;
    cold_resetn = 1'b0;
    pin = 1'b0;
    defer = 1'b0;
    kind = 3'h0;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    ce = 1'b1;
    bready = 1'b0;
    rready = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cold_resetn <= 1'b1;
    @(posedge aclk);
    // Identification words, both pin levels, then writes that must not stick
    for (int p = 0; p < 2; p++)
    begin
      pin <= p[0];
      rdc(`OFS_CACHE_TYPE, ctype(p[0]), `RESP_OKAY);
    end
    rdc(`OFS_ZERO_BLOCK, 32'h4, `RESP_OKAY);
    rdc(`OFS_REC_COUNT, 32'h2, `RESP_OKAY);
    wrc(`OFS_CACHE_TYPE, 32'h0, 4'hf, `RESP_OKAY);
    wrc(`OFS_ZERO_BLOCK, 32'hffffffff, 4'hf, `RESP_OKAY);
    wrc(`OFS_REC_COUNT, 32'hffffffff, 4'hf, `RESP_OKAY);
    rdc(`OFS_CACHE_TYPE, ctype(1'b1), `RESP_OKAY);
    rdc(`OFS_ZERO_BLOCK, 32'h4, `RESP_OKAY);
    rdc(`OFS_REC_COUNT, 32'h2, `RESP_OKAY);
    rdc(6'h3c, 32'h0, `RESP_SLVERR);
    wrc(6'h1c, 32'h1, 4'hf, `RESP_SLVERR);
    // Deferred errors of two kinds, then reserved bits under an all-ones write
    rdc(`OFS_DES_LO, 32'h0, `RESP_OKAY);
    defer_pulse(3'h1);
    rdc(`OFS_DES_LO, 32'h80000411, `RESP_OKAY);
    rdc(`OFS_DES_HI, 32'h0, `RESP_OKAY);
    wrc(`OFS_DES_LO, 32'h0, 4'hf, `RESP_OKAY);
    defer_pulse(3'h0);
    rdc(`OFS_DES_LO, 32'h80000011, `RESP_OKAY);
    wrc(`OFS_DES_LO, 32'hffffffff, 4'hf, `RESP_OKAY);
    wrc(`OFS_DES_HI, 32'hffffffff, 4'hf, `RESP_OKAY);
    rdc(`OFS_DES_LO, 32'h80001c3f, `RESP_OKAY);
    rdc(`OFS_DES_HI, 32'h0, `RESP_OKAY);
    // Frozen by the clock enable: a deferred error of kind 0 must not land
    ce <= 1'b0;
    defer_pulse(3'h0);
    `CHK(arready, 1'b0)
    ce <= 1'b1;
    rdc(`OFS_DES_LO, 32'h80001c3f, `RESP_OKAY);
    // Shared record picked: views read and write it, half-word strobe
    wrc(`OFS_PICK_LO, 32'hffffffff, 4'hf, `RESP_OKAY);
    wrc(`OFS_PICK_HI, 32'hffffffff, 4'hf, `RESP_OKAY);
    rdc(`OFS_PICK_LO, 32'h1, `RESP_OKAY);
    rdc(`OFS_PICK_HI, 32'h0, `RESP_OKAY);
    for (int k = 0; k < 3; k++)
    begin
      rdc(`OFS_ADDR_VIEW_HI + 6'(8 * k), iv(1, k, 1'b1), `RESP_OKAY);
      wrc(`OFS_ADDR_VIEW_LO + 6'(8 * k), 32'h12345670 + k, 4'h3, `RESP_OKAY);
      rdc(`OFS_ADDR_VIEW_LO + 6'(8 * k), {16'hcafe, 16'h5670 + 16'(k)}, `RESP_OKAY);
    end
    // Core record picked: untouched by the writes above
    wrc(`OFS_PICK_LO, 32'h0, 4'hf, `RESP_OKAY);
    for (int k = 0; k < 3; k++)
      rdc(`OFS_ADDR_VIEW_LO + 6'(8 * k), iv(0, k, 1'b0), `RESP_OKAY);
    wrc(`OFS_ADDR_VIEW_LO, 32'h5a5a5a5a, 4'h1, `RESP_OKAY);
    rdc(`OFS_ADDR_VIEW_LO, 32'hcafe005a, `RESP_OKAY);
    wrc(`OFS_CTRL_VIEW_HI, 32'h0000beef, 4'hf, `RESP_OKAY);
    rdc(`OFS_CTRL_VIEW_HI, 32'h0000beef, `RESP_OKAY);
    // Select survives warm reset and clears on cold reset
    wrc(`OFS_PICK_LO, 32'h1, 4'hf, `RESP_OKAY);
    rst(1'b0);
    rdc(`OFS_PICK_LO, 32'h1, `RESP_OKAY);
    rdc(`OFS_ADDR_VIEW_LO, 32'hcafe5670, `RESP_OKAY);
    rst(1'b1);
    rdc(`OFS_PICK_LO, 32'h0, `RESP_OKAY);
    end_sim();
  end
endmodule : cache_id_ras_sysregs_tb

`default_nettype wire

// *** err_record_model.sv ***
// Behavioural error records standing behind the bank's selected-record views.
// Assumes write pulses arrive one cycle wide with their data and strobes.
`timescale 1ns/100ps
`default_nettype none

module err_record_model
  import cache_id_ras_pkg::*;
(
  input wire logic aclk,             // Core clock
  input wire logic cold_resetn,      // Cold reset, active low
  input wire logic core_rec_wr,      // Write pulse, core record
  input wire logic shared_rec_wr,    // Write pulse, shared record
  input wire rec_reg_t rec_wreg,     // Register written
  input wire logic rec_whi,          // Upper word
  input wire logic [31:0] rec_wdata, // Write data
  input wire logic [3:0] rec_wstrb,  // Byte strobes
  output logic [63:0] rec_q [2][3]   // Contents, record then register
);
  // ************************************************************
  // Record storage
  // ************************************************************
  // Byte-wise update, so a partial strobe shows if lanes are crossed
  always_ff @(posedge aclk)
  begin
    if (!cold_resetn)
    begin
      for (int r = 0; r < 2; r++)
        for (int k = 0; k < 3; k++)
          rec_q[r][k] <= {16'hface, 8'(r), 8'(k), 16'hcafe, 8'(r), 8'(k)};
    end
    else if (core_rec_wr || shared_rec_wr)
    begin
      for (int b = 0; b < 4; b++)
        if (rec_wstrb[b])
          rec_q[int'(shared_rec_wr)][int'(rec_wreg)][(rec_whi ? 32 : 0) + b * 8 +: 8] <= rec_wdata[b * 8 +: 8];
    end
  end
endmodule : err_record_model

`default_nettype wire
